/* File: bench/cmpf_analog_model.sv */
`timescale 1ns/100ps
module cmpf_analog_model
	import cmpf_pkg::*;
(
	// channel levels and selection
	input wire logic [63:0] levels,
	input wire cmpf_mux_s mux_sel,
	input wire logic comparator_power,
	// comparison result
	output logic compare_async
);
	logic [7:0] vp;
	logic [7:0] vm;
	assign vp = levels[mux_sel.plus_input_select*8 +: 8];
	assign vm = levels[mux_sel.minus_input_select*8 +: 8];
	// unpowered output is junk, not a clean copy
	assign compare_async = comparator_power ? (vp > vm) : !(vp > vm);
endmodule : cmpf_analog_model

/* File: bench/cmpf_monitor.sv */
`timescale 1ns/100ps
module cmpf_monitor
	import cmpf_pkg::*;
#(
	parameter int AGREE_W = 3,
	parameter int PERIOD_W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire cmpf_bus_s bus_req,
	input wire logic [CMPF_DW-1:0] rdata,
	// analog side
	input wire logic compare_async,
	input wire cmpf_mux_s mux_sel,
	input wire logic comparator_power,
	input wire logic raw_compare_out,
	input wire logic unfiltered_compare_out,
	input wire logic filtered_compare_out,
	input wire logic irq
);
	logic [7:0] ctl_q;
	logic [AGREE_W-1:0] cnt_q;
	logic [PERIOD_W-1:0] per_q;
	logic samp;
	logic same;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// shadows of the mode controls, updated like the real registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ctl_q <= 8'h00;
		else if (bus_req.wr && bus_req.addr == OFS_COMPARE_CONTROL)
			ctl_q <= bus_req.wdata;
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			cnt_q <= '0;
		else if (bus_req.wr && bus_req.addr == OFS_FILTER_CONTROL)
			cnt_q <= bus_req.wdata[AGREE_W-1:0];
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			per_q <= '0;
		else if (bus_req.wr && bus_req.addr == OFS_FILTER_PERIOD)
			per_q <= bus_req.wdata[PERIOD_W-1:0];
	end
	// window or sample enable set counts as continuous
	assign samp = ctl_q[CC_ENABLE_BIT] && ctl_q[7:6] == 2'b00 && cnt_q != '0 && per_q != '0;
	assign same = mux_sel.plus_input_select == mux_sel.minus_input_select;
	a_raw_gated: assert property (raw_compare_out == (comparator_power && compare_async)) else $error("raw");
	a_power_rule: assert property (comparator_power == (ctl_q[CC_ENABLE_BIT] && !same)) else $error("power");
	a_inv_path: assert property (unfiltered_compare_out == (raw_compare_out ^ ctl_q[CC_INVERT_BIT]))
		else $error("invert");
	a_bypass_equal: assert property (!samp |-> filtered_compare_out == unfiltered_compare_out)
		else $error("bypass");
	a_sel_write: assert property (bus_req.wr && bus_req.addr == OFS_INPUT_SELECT
		|=> mux_sel == {$past(bus_req.wdata[7]), $past(bus_req.wdata[5:0])}) else $error("select write");
	a_sel_hold: assert property (!(bus_req.wr && bus_req.addr == OFS_INPUT_SELECT) |=> $stable(mux_sel))
		else $error("select hold");
	a_resv_bit: assert property (bus_req.rd && bus_req.addr == OFS_INPUT_SELECT
		|=> rdata == {mux_sel[6], 1'b0, mux_sel[5:0]}) else $error("select read");
	a_filt_start: assert property ($rose(samp) |-> !filtered_compare_out) else $error("filter start");
	c_sampled: cover property (samp && filtered_compare_out);
	c_irq: cover property ($rose(irq));
	c_off: cover property (ctl_q[CC_ENABLE_BIT] && !comparator_power);
endmodule : cmpf_monitor

bind cmpf_top cmpf_monitor #(.AGREE_W(AGREE_W), .PERIOD_W(PERIOD_W)) u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
	.bus_req(bus_req), .rdata(rdata), .compare_async(compare_async), .mux_sel(mux_sel),
	.comparator_power(comparator_power), .raw_compare_out(raw_compare_out),
	.unfiltered_compare_out(unfiltered_compare_out), .filtered_compare_out(filtered_compare_out), .irq(irq));

/* File: bench/cmpf_top_bench.sv */
`timescale 1ns/100ps
module cmpf_top_bench
	import cmpf_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	cmpf_bus_s bus_req = '0;
	logic [63:0] levels = '0;
	logic [7:0] rdata, r, d;
	logic compare_async, power, raw, unf, filt, irq, e;
	cmpf_mux_s mux_sel;
	integer seed = 90442;
	int n_mismatch = 0;
	int checks_done = 0;
	always #12.5 sys_clk = ~sys_clk;
	cmpf_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
		.compare_async(compare_async), .mux_sel(mux_sel), .comparator_power(power), .raw_compare_out(raw),
		.unfiltered_compare_out(unf), .filtered_compare_out(filt), .irq(irq));
	cmpf_analog_model u_ana (.levels(levels), .mux_sel(mux_sel), .comparator_power(power),
		.compare_async(compare_async));
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		bus_req <= '{a, v, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		@(negedge sys_clk);
		v = rdata;
	endtask : rd
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		checks_done++;
		if (s !== x) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	// channel 1 against channel 2 only
	task automatic lvl(input logic h, input int n);
		@(posedge sys_clk);
		levels <= h ? 64'h0000_FF00 : 64'h00FF_0000;
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : lvl
	function automatic logic exp_cmp(input logic [63:0] l, input logic [2:0] p, input logic [2:0] m);
		return l[p*8 +: 8] > l[m*8 +: 8];
	endfunction : exp_cmp
	task automatic summarize();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	initial begin
		#200000;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], r);
			chk(r, 8'h00);
		end
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hFF : 8'($random(seed));
			wr(OFS_INPUT_SELECT, d);
			// let the write edge settle before looking at the register outputs
			@(negedge sys_clk);
			chk({1'b0, mux_sel}, {1'b0, d[7], d[5:0]});
			rd(OFS_INPUT_SELECT, r);
			chk(r, d & 8'hBF);
		end
		$display("test select done");
		// window and sample enables stay clear: only legal, unsampled settings
		wr(OFS_COMPARE_CONTROL, 8'h01);
		wr(OFS_INPUT_SELECT, 8'h1B);
		@(negedge sys_clk);
		chk(8'(power), 8'h00);
		wr(OFS_INPUT_SELECT, 8'h0A);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			levels <= {$random(seed), $random(seed)};
			repeat (6) @(posedge sys_clk);
			e = exp_cmp(levels, 3'h1, 3'h2);
			chk(8'(unf), 8'(e));
			chk(8'(filt), 8'(e));
			rd(OFS_STATUS_CONTROL, r);
			chk(8'(r[0]), 8'(e));
		end
		$display("test continuous done");
		lvl(1'b1, 8);
		wr(OFS_STATUS_CONTROL, 8'h06);
		wr(OFS_STATUS_CONTROL, 8'h08);
		lvl(1'b0, 8);
		chk(8'(irq), 8'h01);
		rd(OFS_STATUS_CONTROL, r);
		chk(r, 8'h0A);
		wr(OFS_STATUS_CONTROL, 8'h0A);
		rd(OFS_STATUS_CONTROL, r);
		chk({r[7:1], irq}, 8'h08);
		lvl(1'b1, 8);
		chk(8'(irq), 8'h00);
		rd(OFS_STATUS_CONTROL, r);
		chk(r, 8'h0D);
		wr(OFS_STATUS_CONTROL, 8'h14);
		rd(OFS_STATUS_CONTROL, r);
		chk(r, 8'h11);
		$display("test edges done");
		wr(OFS_COMPARE_CONTROL, 8'h08);
		rd(OFS_STATUS_CONTROL, r);
		chk({raw, 6'h00, r[0]}, 8'h01);
		// filter settings change only from the cleared state
		wr(OFS_COMPARE_CONTROL, 8'h00);
		wr(OFS_FILTER_CONTROL, 8'h00);
		wr(OFS_FILTER_PERIOD, 8'h04);
		wr(OFS_FILTER_CONTROL, 8'h01);
		wr(OFS_COMPARE_CONTROL, 8'h01);
		@(negedge sys_clk);
		chk(8'(filt), 8'h00);
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(8'(filt), 8'h01);
		// filter output rose with the rising interrupt enabled
		chk(8'(irq), 8'h01);
		lvl(1'b0, 20);
		chk(8'(filt), 8'h00);
		wr(OFS_COMPARE_CONTROL, 8'h00);
		wr(OFS_FILTER_CONTROL, 8'h00);
		wr(OFS_FILTER_CONTROL, 8'h03);
		wr(OFS_COMPARE_CONTROL, 8'h01);
		lvl(1'b1, 7);
		chk(8'(filt), 8'h00);
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(8'(filt), 8'h01);
		$display("test filter done");
		summarize();
	end
endmodule : cmpf_top_bench

/* File: hw/cmpf_filter.sv */
`timescale 1ns/100ps
module cmpf_filter
	import cmpf_pkg::*;
#(
	parameter int AGREE_W = 3,
	parameter int PERIOD_W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// settings
	input wire logic clear,
	input wire logic [AGREE_W-1:0] agree_count,
	input wire logic [PERIOD_W-1:0] period,
	// data
	input wire logic sample_in,
	output logic filt_out
);
	logic [PERIOD_W-1:0] period_cnt_q;
	logic [AGREE_W-1:0] agree_cnt_q;
	logic tick;

	assign tick = (period_cnt_q == period - PERIOD_W'(1));

	// sample timebase in bus clock cycles
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			period_cnt_q <= '0;
		end else if (clear || tick) begin
			period_cnt_q <= '0;
		end else begin
			period_cnt_q <= period_cnt_q + PERIOD_W'(1);
		end
	end

	// output moves only after agree_count consecutive differing samples
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			agree_cnt_q <= '0;
			filt_out <= 1'b0;
		end else if (clear) begin
			agree_cnt_q <= '0;
			filt_out <= 1'b0;
		end else if (tick) begin
			if (sample_in == filt_out) begin
				agree_cnt_q <= '0;
			end else if (agree_cnt_q + AGREE_W'(1) >= agree_count) begin
				agree_cnt_q <= '0;
				filt_out <= sample_in;
			end else begin
				agree_cnt_q <= agree_cnt_q + AGREE_W'(1);
			end
		end
	end
endmodule : cmpf_filter

/* File: hw/cmpf_pkg.sv */
// Operation
// - pass-through bit switches mux pass-through mode
// - mux select bit 6 reads zero
// - plus select code picks channel 0-7
// - minus select code picks channel 0-7
// - equal selects shut comparator down
// - compare high when plus exceeds minus; invertible
// - edge irq enables choose interrupt sources
// - edge flags set on compare transitions
// - compare output readable as status bit
// - internal-clock filter, N agreeing samples
// - mode decode from count and period
// - disabled mode forces raw output low
// - continuous mode bypasses sampling, combinational status
// - continuous mode: filtered equals unfiltered
// - sampled mode captures on sample tick
// - count one: plain sample-and-hold
// - zero count resets filter state
// - period counts bus clocks; zero disables
// - edge flags clear on write one
// - filter output starts zero, needs agreement
package cmpf_pkg;
	localparam int CMPF_AW = 3;
	localparam int CMPF_DW = 8;

	// byte offsets of the register file
	localparam logic [CMPF_AW-1:0] OFS_FILTER_CONTROL = 3'h0;
	localparam logic [CMPF_AW-1:0] OFS_COMPARE_CONTROL = 3'h1;
	localparam logic [CMPF_AW-1:0] OFS_FILTER_PERIOD = 3'h2;
	localparam logic [CMPF_AW-1:0] OFS_STATUS_CONTROL = 3'h3;
	localparam logic [CMPF_AW-1:0] OFS_INPUT_SELECT = 3'h5;

	// compare_control_reg fields
	localparam int CC_ENABLE_BIT = 0;
	localparam int CC_INVERT_BIT = 3;
	localparam int CC_WINDOW_BIT = 6;
	localparam int CC_SAMPLE_BIT = 7;

	// status_control_reg fields
	localparam int SC_FILTERED_COMPARE_OUT_BIT = 0;
	localparam int SC_FALL_FLAG_BIT = 1;
	localparam int SC_RISE_FLAG_BIT = 2;
	localparam int SC_FALL_IE_BIT = 3;
	localparam int SC_RISE_IE_BIT = 4;

	// input select fields
	localparam int IS_PASS_BIT = 7;
	localparam int IS_PLUS_LSB = 3;
	localparam int IS_MINUS_LSB = 0;

	// reset values
	localparam logic [CMPF_DW-1:0] RST_FILTER_CONTROL = 8'h00;
	localparam logic [CMPF_DW-1:0] RST_COMPARE_CONTROL = 8'h00;
	localparam logic [CMPF_DW-1:0] RST_FILTER_PERIOD = 8'h00;
	localparam logic [CMPF_DW-1:0] RST_INPUT_SELECT = 8'h00;
	localparam logic [CMPF_DW-1:0] RST_READ_DATA = 8'h00;

	// synchroniser depth
	localparam int SYNC_STAGES = 3;

	typedef enum logic [3:0] {
		MODE_DISABLED = 4'h1,
		MODE_CONTINUOUS = 4'h2,
		MODE_SAMPLED = 4'h4,
		MODE_FILTERED = 4'h8
	} cmpf_mode_e;

	typedef struct packed {
		logic [CMPF_AW-1:0] addr;
		logic [CMPF_DW-1:0] wdata;
		logic wr;
		logic rd;
	} cmpf_bus_s;

	typedef struct packed {
		logic pass_through_enable;
		logic [2:0] plus_input_select;
		logic [2:0] minus_input_select;
	} cmpf_mux_s;
endpackage : cmpf_pkg

/* File: hw/cmpf_sync.sv */
`timescale 1ns/100ps
module cmpf_sync
	import cmpf_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// asynchronous level and its clean copy
	input wire logic async_in,
	output logic level_out
);
	logic [SYNC_STAGES-1:0] stage_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= {stage_q[SYNC_STAGES-2:0], async_in};
		end
	end

	// a change counts only once the last two stages agree
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			level_out <= 1'b0;
		end else if (stage_q[1] == stage_q[2]) begin
			level_out <= stage_q[2];
		end
	end
endmodule : cmpf_sync

/* File: hw/cmpf_top.sv */
// The strobed register port was decided locally.
`timescale 1ns/100ps
module cmpf_top
	import cmpf_pkg::*;
#(
	parameter int AGREE_W = 3,
	parameter int PERIOD_W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire cmpf_bus_s bus_req,
	output logic [CMPF_DW-1:0] rdata,
	// analog side: result of plus > minus, asynchronous
	input wire logic compare_async,
	output cmpf_mux_s mux_sel,
	output logic comparator_power,
	output logic raw_compare_out,
	output logic unfiltered_compare_out,
	output logic filtered_compare_out,
	// processor side
	output logic irq
);
	logic [CMPF_DW-1:0] filter_control_q;
	logic [CMPF_DW-1:0] compare_control_q;
	logic [CMPF_DW-1:0] filter_period_q;
	logic [CMPF_DW-1:0] input_select_q;
	logic rise_irq_enable_q;
	logic fall_irq_enable_q;
	logic rise_edge_flag_q;
	logic fall_edge_flag_q;
	logic edge_prev_q;
	logic rdata_q;
	logic [CMPF_DW-1:0] rdata_d;
	logic [CMPF_DW-1:0] rdata_r_q;

	logic enable;
	logic output_invert;
	logic window_enable;
	logic sample_enable;
	logic [AGREE_W-1:0] sample_agree_count;
	logic [PERIOD_W-1:0] sample_period;
	logic same_channel;
	logic sync_level;
	logic filt_level;
	logic edge_src;
	logic rise_evt;
	logic fall_evt;
	logic wr_status;
	cmpf_mode_e mode;

	function automatic logic hit(input cmpf_bus_s req, input logic [CMPF_AW-1:0] ofs);
		hit = req.wr && (req.addr == ofs);
	endfunction : hit

	assign enable = compare_control_q[CC_ENABLE_BIT];
	assign output_invert = compare_control_q[CC_INVERT_BIT];
	assign window_enable = compare_control_q[CC_WINDOW_BIT];
	assign sample_enable = compare_control_q[CC_SAMPLE_BIT];
	assign sample_agree_count = filter_control_q[AGREE_W-1:0];
	assign sample_period = filter_period_q[PERIOD_W-1:0];

	// register writes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			filter_control_q <= RST_FILTER_CONTROL;
			compare_control_q <= RST_COMPARE_CONTROL;
			filter_period_q <= RST_FILTER_PERIOD;
		end else begin
			if (hit(bus_req, OFS_FILTER_CONTROL)) begin
				filter_control_q <= {{(CMPF_DW-AGREE_W){1'b0}}, bus_req.wdata[AGREE_W-1:0]};
			end
			if (hit(bus_req, OFS_COMPARE_CONTROL)) begin
				compare_control_q <= bus_req.wdata;
			end
			if (hit(bus_req, OFS_FILTER_PERIOD)) begin
				filter_period_q <= bus_req.wdata;
			end
		end
	end

	// bit 6 never stores, so it reads back zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			input_select_q <= RST_INPUT_SELECT;
		end else if (hit(bus_req, OFS_INPUT_SELECT)) begin
			input_select_q <= bus_req.wdata & 8'hBF;
		end
	end

	assign mux_sel.pass_through_enable = input_select_q[IS_PASS_BIT];
	assign mux_sel.plus_input_select = input_select_q[IS_PLUS_LSB+:3];
	assign mux_sel.minus_input_select = input_select_q[IS_MINUS_LSB+:3];

	// equal selects would turn the comparator into a noise source
	assign same_channel = (mux_sel.plus_input_select == mux_sel.minus_input_select);
	assign comparator_power = enable && !same_channel;

	// mode decode; window or sample enable set is not a legal setting and falls back to continuous
	always_comb begin
		if (!enable) begin
			mode = MODE_DISABLED;
		end else if (window_enable || sample_enable) begin
			mode = MODE_CONTINUOUS;
		end else if (sample_agree_count == '0 || sample_period == '0) begin
			mode = MODE_CONTINUOUS;
		end else if (sample_agree_count == AGREE_W'(1)) begin
			mode = MODE_SAMPLED;
		end else begin
			mode = MODE_FILTERED;
		end
	end

	// analog path stays unclocked
	assign raw_compare_out = comparator_power && compare_async;
	assign unfiltered_compare_out = raw_compare_out ^ output_invert;

	cmpf_sync u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(unfiltered_compare_out),
		.level_out(sync_level)
	);

	// leaving the sampled modes clears the filter to its known state
	cmpf_filter #(
		.AGREE_W(AGREE_W),
		.PERIOD_W(PERIOD_W)
	) u_filter (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clear(mode != MODE_SAMPLED && mode != MODE_FILTERED),
		.agree_count(sample_agree_count),
		.period(sample_period),
		.sample_in(sync_level),
		.filt_out(filt_level)
	);

	// continuous mode: no sampling at all, output follows the comparator
	always_comb begin
		case (mode)
			MODE_SAMPLED, MODE_FILTERED: filtered_compare_out = filt_level;
			default: filtered_compare_out = unfiltered_compare_out;
		endcase
	end

	// edges are judged on synchronous values only
	always_comb begin
		case (mode)
			MODE_SAMPLED, MODE_FILTERED: edge_src = filt_level;
			default: edge_src = sync_level;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_prev_q <= 1'b0;
		end else begin
			edge_prev_q <= edge_src;
		end
	end

	assign rise_evt = edge_src && !edge_prev_q;
	assign fall_evt = !edge_src && edge_prev_q;
	assign wr_status = hit(bus_req, OFS_STATUS_CONTROL);

	// a new edge wins over a same-cycle write-one clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rise_edge_flag_q <= 1'b0;
			fall_edge_flag_q <= 1'b0;
		end else begin
			if (rise_evt) begin
				rise_edge_flag_q <= 1'b1;
			end else if (wr_status && bus_req.wdata[SC_RISE_FLAG_BIT]) begin
				rise_edge_flag_q <= 1'b0;
			end
			if (fall_evt) begin
				fall_edge_flag_q <= 1'b1;
			end else if (wr_status && bus_req.wdata[SC_FALL_FLAG_BIT]) begin
				fall_edge_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rise_irq_enable_q <= 1'b0;
			fall_irq_enable_q <= 1'b0;
		end else if (wr_status) begin
			rise_irq_enable_q <= bus_req.wdata[SC_RISE_IE_BIT];
			fall_irq_enable_q <= bus_req.wdata[SC_FALL_IE_BIT];
		end
	end

	assign irq = (rise_edge_flag_q && rise_irq_enable_q) || (fall_edge_flag_q && fall_irq_enable_q);

	// read data, valid the cycle after the strobe
	always_comb begin
		rdata_d = RST_READ_DATA;
		case (bus_req.addr)
			OFS_FILTER_CONTROL: rdata_d = filter_control_q;
			OFS_COMPARE_CONTROL: rdata_d = compare_control_q;
			OFS_FILTER_PERIOD: rdata_d = filter_period_q;
			OFS_STATUS_CONTROL: begin
				rdata_d[SC_FILTERED_COMPARE_OUT_BIT] = filtered_compare_out;
				rdata_d[SC_FALL_FLAG_BIT] = fall_edge_flag_q;
				rdata_d[SC_RISE_FLAG_BIT] = rise_edge_flag_q;
				rdata_d[SC_FALL_IE_BIT] = fall_irq_enable_q;
				rdata_d[SC_RISE_IE_BIT] = rise_irq_enable_q;
			end
			OFS_INPUT_SELECT: rdata_d = input_select_q;
			default: rdata_d = RST_READ_DATA;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r_q <= RST_READ_DATA;
			rdata_q <= 1'b0;
		end else begin
			rdata_q <= bus_req.rd;
			if (bus_req.rd) begin
				rdata_r_q <= rdata_d;
			end
		end
	end

	assign rdata = rdata_q ? rdata_r_q : RST_READ_DATA;
endmodule : cmpf_top
